/* hw/hlv_pkg.sv */
// What this block does
// - Raise the event flag when the watched voltage passes the trip point.
// - Event flag with its enable drives the interrupt so software can respond.
// - Direction 1 trips at or above the level; 0 at or below.
// - Band gap stable bit is read-only and mirrors the band gap ready input.
// - Reference stable bit reads 1 only while the flag can be raised.
// - Top trip level code routes the comparator to the external sense pin while the detector is enabled.
// - Reference stable is read-only, held low for a settling time after each enable.
// - No event flag until the circuit is stable and reference stable is set.
// - Trip level all ones selects external-input mode while the detector is enabled.
// - Reset returns the control register to its reset state, detector off.
package hlv_pkg;

   // Register addresses on the plain register port
   localparam int              ADDR_W          = 12;
   localparam logic [11:0]     ADDR_CTRL       = 12'hF85;
   localparam logic [11:0]     ADDR_STATUS     = 12'hF86;
   localparam logic [11:0]     ADDR_MASK       = 12'hF87;

   // Control register field positions
   localparam int              BIT_DIR         = 7;
   localparam int              BIT_BGAP        = 6;
   localparam int              BIT_REFST       = 5;
   localparam int              BIT_EN          = 4;
   localparam int              LVL_LSB         = 0;
   localparam int              LVL_W           = 4;
   // Status and mask layout
   localparam int              BIT_EVENT       = 0;

   // Reset values and the external-input level code
   localparam logic [7:0]      CTRL_RST        = 8'h00;
   localparam logic [LVL_W-1:0] LVL_EXT        = 4'hF;
   localparam logic [7:0]      RD_ZERO         = 8'h00;

   // Settling time of the reference after each enable
   localparam int              CLK_PERIOD_NS   = 100;
   localparam int              T_SETTLE_NS     = 20000;
   localparam int              CNT_W           = 8;
   localparam logic [CNT_W-1:0] SETTLE_CYC     =
      CNT_W'((T_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] CNT_ZERO       = 8'h00;
   localparam logic [CNT_W-1:0] CNT_ONE        = 8'h01;

   // Synchroniser lane order
   localparam int              SYNC_W          = 4;
   localparam int              SY_GE           = 0;
   localparam int              SY_LE           = 1;
   localparam int              SY_REF          = 2;
   localparam int              SY_BGAP         = 3;

   typedef enum logic [2:0] {
      HLV_OFF    = 3'h1,
      HLV_SETTLE = 3'h2,
      HLV_READY  = 3'h4
   } hlv_state_t;

endpackage : hlv_pkg

/* hw/hlv_sync_if.sv */
`timescale 1ns/1ns
`default_nettype none
// Raw analog-side levels in, clock-aligned levels out
interface hlv_sync_if;
   logic [3:0] raw;
   logic [3:0] sync;
   modport user (output raw, input sync);
   modport sync_side (input raw, output sync);
endinterface : hlv_sync_if
`default_nettype wire

/* hw/hlv_sync.sv */
`timescale 1ns/1ns
`default_nettype none
module hlv_sync
   import hlv_pkg::*;
(
   input  wire logic       i_sys_clk,
   input  wire logic       i_rst,
   hlv_sync_if.sync_side   s_if
);

   typedef struct packed {
      logic [SYNC_W-1:0] meta;
      logic [SYNC_W-1:0] stab;
   } hlv_sync_st_t;

   hlv_sync_st_t st_r;
   hlv_sync_st_t st_nxt;

   always_comb begin
      st_nxt      = st_r;
      st_nxt.meta = s_if.raw;
      st_nxt.stab = st_r.meta;
   end

   // Constant reset only; first stage feeds second stage alone
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign s_if.sync = st_r.stab;

   sync_delay_a: assert property (
      @(posedge i_sys_clk) disable iff (i_rst)
      !$past(i_rst, 2) |-> s_if.sync == $past(s_if.raw, 2))
      else $error("synchronised level does not follow input after two clocks");

endmodule : hlv_sync
`default_nettype wire

/* hw/hlv_ctrl.sv */
// Implementation choice: the strobed register port.
`timescale 1ns/1ns
`default_nettype none
module hlv_ctrl
   import hlv_pkg::*;
(
   input  wire logic              i_sys_clk,
   input  wire logic              i_rst,
   input  wire logic [ADDR_W-1:0] i_addr,
   input  wire logic [7:0]        i_wdata,
   input  wire logic              i_wr,
   input  wire logic              i_rd,
   output logic [7:0]             o_rdata,
   input  wire logic              i_cmp_ge,
   input  wire logic              i_cmp_le,
   input  wire logic              i_ref_ready,
   input  wire logic              i_bgap_ready,
   output logic                   o_det_enable,
   output logic [LVL_W-1:0]       o_trip_level,
   output logic                   o_ext_sense_sel,
   output logic                   o_irq
);

   // All block state in one record
   typedef struct packed {
      logic              dir;
      logic              en;
      logic [LVL_W-1:0]  lvl;
      hlv_state_t        st;
      logic [CNT_W-1:0]  cnt;
      logic              flag;
      logic              mask;
      logic [7:0]        rdata;
   } hlv_regs_t;

   hlv_regs_t r_r;
   hlv_regs_t r_nxt;

   hlv_sync_if s_if ();

   logic       ge_s;
   logic       le_s;
   logic       ref_s;
   logic       bgap_s;
   logic       ref_stable;
   logic       trip_hit;
   logic       wr_ctrl;
   logic       wr_stat;
   logic       wr_mask;
   logic       en_rise;
   logic [7:0] ctrl_view;

   // analog levels cross into the clock domain
   assign s_if.raw[SY_GE]   = i_cmp_ge;
   assign s_if.raw[SY_LE]   = i_cmp_le;
   assign s_if.raw[SY_REF]  = i_ref_ready;
   assign s_if.raw[SY_BGAP] = i_bgap_ready;

   hlv_sync hlv_sync_inst (
      .i_sys_clk (i_sys_clk),
      .i_rst     (i_rst),
      .s_if      (s_if)
   );

   // Synchronised copies, the only form the logic sees
   assign ge_s   = s_if.sync[SY_GE];
   assign le_s   = s_if.sync[SY_LE];
   assign ref_s  = s_if.sync[SY_REF];
   assign bgap_s = s_if.sync[SY_BGAP];

   // Write decode, one strobe per register
   assign wr_ctrl = i_wr && (i_addr == ADDR_CTRL);
   assign wr_stat = i_wr && (i_addr == ADDR_STATUS);
   assign wr_mask = i_wr && (i_addr == ADDR_MASK);
   assign en_rise = wr_ctrl && i_wdata[BIT_EN] && !r_r.en;

   // stable only once events can really be flagged
   assign ref_stable = (r_r.st == HLV_READY);

   // direction picks which comparator sense counts
   assign trip_hit = r_r.dir ? ge_s : le_s;

   // read-only bits come from live state, not storage
   always_comb begin
      ctrl_view              = RD_ZERO;
      ctrl_view[BIT_DIR]     = r_r.dir;
      ctrl_view[BIT_BGAP]    = bgap_s;
      ctrl_view[BIT_REFST]   = ref_stable;
      ctrl_view[BIT_EN]      = r_r.en;
      ctrl_view[LVL_LSB +: LVL_W] = r_r.lvl;
   end

   // Next-state logic for the whole block
   always_comb begin
      r_nxt = r_r;

      if (wr_ctrl) begin
         r_nxt.dir = i_wdata[BIT_DIR];
         r_nxt.en  = i_wdata[BIT_EN];
         r_nxt.lvl = i_wdata[LVL_LSB +: LVL_W];
      end

      // Interrupt enable for the event flag
      if (wr_mask) begin
         r_nxt.mask = i_wdata[BIT_EVENT];
      end

      case (r_r.st)
         HLV_OFF: begin
            r_nxt.cnt = CNT_ZERO;
            if (en_rise) begin
               r_nxt.st  = HLV_SETTLE;
               r_nxt.cnt = SETTLE_CYC;
            end
         end
         HLV_SETTLE: begin
            if (r_r.cnt != CNT_ZERO) begin
               r_nxt.cnt = r_r.cnt - CNT_ONE;
            end else if (ref_s) begin
               // Timer alone is not trusted; analog ready must agree
               r_nxt.st = HLV_READY;
            end
         end
         HLV_READY: begin
            // Reference dropping out sends us back to wait again
            if (!ref_s) begin
               r_nxt.st  = HLV_SETTLE;
               r_nxt.cnt = SETTLE_CYC;
            end
         end
         default: begin
            r_nxt.st  = HLV_OFF;
            r_nxt.cnt = CNT_ZERO;
         end
      endcase

      // disabling drops the state machine and counter back to off at once; flag and mask keep their values
      if (wr_ctrl && !i_wdata[BIT_EN]) begin
         r_nxt.st  = HLV_OFF;
         r_nxt.cnt = CNT_ZERO;
      end

      // Write-one-to-clear on the event flag
      if (wr_stat && i_wdata[BIT_EVENT]) begin
         r_nxt.flag = 1'h0;
      end
      // gated by stability; set wins over the clear
      if (ref_stable && trip_hit) begin
         r_nxt.flag = 1'h1;
      end

      // Read data land one cycle after the strobe; unmapped reads zero
      r_nxt.rdata = RD_ZERO;
      if (i_rd) begin
         case (i_addr)
            ADDR_CTRL: begin
               r_nxt.rdata = ctrl_view;
            end
            ADDR_STATUS: begin
               r_nxt.rdata[BIT_EVENT] = r_r.flag;
            end
            ADDR_MASK: begin
               r_nxt.rdata[BIT_EVENT] = r_r.mask;
            end
            default: begin
               r_nxt.rdata = RD_ZERO;
            end
         endcase
      end
   end

   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         r_r.dir   <= CTRL_RST[BIT_DIR];
         r_r.en    <= CTRL_RST[BIT_EN];
         r_r.lvl   <= CTRL_RST[LVL_LSB +: LVL_W];
         r_r.st    <= HLV_OFF;
         r_r.cnt   <= CNT_ZERO;
         r_r.flag  <= 1'h0;
         r_r.mask  <= 1'h0;
         r_r.rdata <= RD_ZERO;
      end else begin
         r_r <= r_nxt;
      end
   end

   // Analog-side controls, all from flops
   assign o_det_enable = r_r.en;
   assign o_trip_level = r_r.lvl;
   assign o_ext_sense_sel = r_r.en && (r_r.lvl == LVL_EXT);
   // level interrupt while flag and enable both set
   assign o_irq = r_r.flag && r_r.mask;
   assign o_rdata = r_r.rdata;

   // Checks on the block's own behaviour
   default clocking cb @(posedge i_sys_clk);
   endclocking
   default disable iff (i_rst);

   rise_flag_a: assert property (
      ref_stable && r_r.dir && ge_s |=> r_r.flag)
      else $error("high-side crossing did not set event flag");

   fall_flag_a: assert property (
      ref_stable && !r_r.dir && le_s && !ge_s |=> r_r.flag)
      else $error("low-side crossing did not set event flag");

   wrong_dir_a: assert property (
      !r_r.flag && r_r.dir && !ge_s && le_s |=> !r_r.flag)
      else $error("event flag set for the wrong direction");

   irq_follow_a: assert property (
      r_r.mask && !wr_mask && ref_stable && trip_hit |=> o_irq)
      else $error("enabled event did not raise interrupt");

   bgap_read_a: assert property (
      i_rd && (i_addr == ADDR_CTRL) |=> o_rdata[BIT_BGAP] == $past(bgap_s))
      else $error("band gap stable bit reads wrong");

   settle_hold_a: assert property (
      en_rise |=> !ref_stable [*8])
      else $error("reference stable set too early after enable");

   no_early_a: assert property (
      !ref_stable && !r_r.flag |=> !r_r.flag)
      else $error("event flag set before reference was stable");

   ext_mode_a: assert property (
      wr_ctrl && i_wdata[BIT_EN] && (i_wdata[LVL_LSB +: LVL_W] == LVL_EXT)
      |=> o_ext_sense_sel && o_trip_level == LVL_EXT)
      else $error("external sense mode not selected");

   disable_a: assert property (
      wr_ctrl && !i_wdata[BIT_EN] |=> !o_det_enable && !ref_stable)
      else $error("detector stayed on after disable write");

   // Main scenarios worth seeing
   settle_done_c: cover property ($rose(ref_stable));
   event_set_c: cover property ($rose(r_r.flag));
   irq_raise_c: cover property ($rose(o_irq));
   set_over_clr_c: cover property (wr_stat && i_wdata[BIT_EVENT] && ref_stable && trip_hit);

endmodule : hlv_ctrl
`default_nettype wire

/* dv/hlv_analog_model.sv */
`timescale 1ns/1ns
`default_nettype none
// Comparator, divider and reference on the analog side, in clock steps
module hlv_analog_model (
   input  wire logic       i_sys_clk,
   input  wire logic       i_det_enable,
   input  wire logic [3:0] i_trip_level,
   input  wire logic       i_ext_sense_sel,
   input  wire logic [4:0] i_supply,
   input  wire logic [4:0] i_ext_volt,
   input  wire logic       i_bgap_ok,
   input  wire logic [9:0] i_ready_dly,
   output logic            o_cmp_ge,
   output logic            o_cmp_le,
   output logic            o_ref_ready,
   output logic            o_bgap_ready
);
   logic [9:0] cnt_r = 10'h000;
   logic [4:0] watched;
   // Warm-up restarts at every power-up; delay set by the bench, fast or slow
   always @(posedge i_sys_clk) begin
      if (!i_det_enable) cnt_r <= 10'h000;
      else if (cnt_r != 10'h3FF) cnt_r <= cnt_r + 10'h001;
   end
   assign o_ref_ready = i_det_enable && (cnt_r >= i_ready_dly);
   // Sense pin or supply feeds the comparator
   assign watched = i_ext_sense_sel ? i_ext_volt : i_supply;
   // Equality trips both ways; unpowered comparator sits low
   assign o_cmp_ge = i_det_enable && (watched >= {1'h0, i_trip_level});
   assign o_cmp_le = i_det_enable && (watched <= {1'h0, i_trip_level});
   // Band gap state comes from the bench
   assign o_bgap_ready = i_bgap_ok;
endmodule : hlv_analog_model
`default_nettype wire

/* dv/hlv_ctrl_bench.sv */
`timescale 1ns/1ns
`default_nettype none
module hlv_ctrl_bench
   import hlv_pkg::*;
;
   logic              clk = 1'h0;
   logic              rst = 1'h1;
   logic [ADDR_W-1:0] addr = 12'h000;
   logic [7:0]        wdata = 8'h00;
   logic              wr = 1'h0;
   logic              rd = 1'h0;
   logic [7:0]        rdata;
   logic              ge, le, refr, bgr, den, ext_sel, irq;
   logic [3:0]        lvl;
   logic [4:0]        supply = 5'h0A;
   logic [4:0]        ext_volt = 5'h00;
   logic              bgap_ok = 1'h1;
   logic [9:0]        ready_dly = 10'h12C;
   int                fails = 0;
   int                cmp_count = 0;
   int                cycles = 0;

   hlv_ctrl hlv_ctrl_inst (.i_sys_clk(clk), .i_rst(rst), .i_addr(addr), .i_wdata(wdata),
      .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_cmp_ge(ge), .i_cmp_le(le),
      .i_ref_ready(refr), .i_bgap_ready(bgr), .o_det_enable(den), .o_trip_level(lvl),
      .o_ext_sense_sel(ext_sel), .o_irq(irq));
   hlv_analog_model hlv_analog_model_inst (.i_sys_clk(clk), .i_det_enable(den),
      .i_trip_level(lvl), .i_ext_sense_sel(ext_sel), .i_supply(supply),
      .i_ext_volt(ext_volt), .i_bgap_ok(bgap_ok), .i_ready_dly(ready_dly),
      .o_cmp_ge(ge), .o_cmp_le(le), .o_ref_ready(refr), .o_bgap_ready(bgr));

   // 100 ns clock
   initial begin
      forever #50 clk = ~clk;
   end

   task automatic check_val(input logic [7:0] seen, input logic [7:0] exp, input string msg);
      cmp_count++;
      if (seen !== exp) begin
         fails++;
         $display("Error at %0t ns: %s seen %h expected %h", $time, msg, seen, exp);
      end
   endtask : check_val

   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : print_verdict

   // One-cycle write strobe; returns mid-cycle so outputs have settled
   task automatic reg_wr(input logic [11:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'h1;
      @(posedge clk);
      wr <= 1'h0;
      @(negedge clk);
   endtask : reg_wr

   // Read data stands only in the cycle after the strobe
   task automatic reg_rd(input logic [11:0] a, input logic [7:0] exp, input string msg);
      @(posedge clk);
      addr <= a;
      rd <= 1'h1;
      @(posedge clk);
      rd <= 1'h0;
      @(negedge clk);
      check_val(rdata, exp, msg);
   endtask : reg_rd

   task automatic t_reset();
      repeat (3) @(posedge clk);
      reg_rd(ADDR_CTRL, 8'h40, "ctrl after reset");
      check_val({7'h00, den}, 8'h00, "detector off");
      reg_wr(12'hF88, 8'hFF);
      reg_rd(12'hF88, 8'h00, "unmapped read");
      reg_rd(ADDR_STATUS, 8'h00, "status after reset");
      reg_rd(ADDR_MASK, 8'h00, "mask after reset");
      $display("test reset done");
   endtask : t_reset

   // Slow reference: crossing present from the start must wait for stability
   task automatic t_settle();
      reg_wr(ADDR_CTRL, 8'hF5);
      check_val({3'h0, den, lvl}, 8'h15, "enable and level");
      repeat (250) @(posedge clk);
      reg_rd(ADDR_CTRL, 8'hD5, "still settling");
      reg_rd(ADDR_STATUS, 8'h00, "no early flag");
      repeat (70) @(posedge clk);
      reg_rd(ADDR_CTRL, 8'hF5, "reference stable");
      reg_rd(ADDR_STATUS, 8'h01, "rise event");
      $display("test settle done");
   endtask : t_settle

   task automatic t_fall_irq();
      ready_dly <= 10'h00A;
      reg_wr(ADDR_CTRL, 8'h00);
      reg_rd(ADDR_CTRL, 8'h40, "disabled view");
      reg_wr(ADDR_CTRL, 8'h18);
      repeat (210) @(posedge clk);
      // clear a stale flag before unmasking
      reg_wr(ADDR_STATUS, 8'h01);
      reg_rd(ADDR_STATUS, 8'h00, "above level, falling mode");
      // unmask only once reference stable reads 1
      reg_rd(ADDR_CTRL, 8'h78, "stable before unmask");
      reg_wr(ADDR_MASK, 8'h01);
      check_val({7'h00, irq}, 8'h00, "irq idle");
      supply <= 5'h08;
      @(posedge clk);
      #1 check_val({7'h00, irq}, 8'h00, "irq before sync");
      repeat (2) @(posedge clk);
      #1 check_val({7'h00, irq}, 8'h01, "irq on equal");
      reg_wr(ADDR_MASK, 8'h00);
      check_val({7'h00, irq}, 8'h00, "irq masked");
      supply <= 5'h0C;
      repeat (3) @(posedge clk);
      reg_wr(ADDR_STATUS, 8'h01);
      reg_rd(ADDR_STATUS, 8'h00, "flag cleared");
      $display("test fall_irq done");
   endtask : t_fall_irq

   task automatic t_levels();
      for (int i = 0; i < 16; i++) begin
         reg_wr(ADDR_CTRL, {4'h1, 4'(i)});
         check_val({3'h0, ext_sel, lvl}, {3'h0, 1'(i == 15), 4'(i)}, "level");
      end
      reg_wr(ADDR_CTRL, 8'h9F);
      reg_rd(ADDR_CTRL, 8'hFF, "no resettle on re-enable");
      supply <= 5'h14;
      repeat (3) @(posedge clk);
      reg_wr(ADDR_STATUS, 8'h01);
      reg_rd(ADDR_STATUS, 8'h00, "supply ignored");
      ext_volt <= 5'h10;
      repeat (3) @(posedge clk);
      reg_rd(ADDR_STATUS, 8'h01, "sense pin event");
      $display("test levels done");
   endtask : t_levels

   task automatic t_bgap();
      // Clear while the crossing persists: the set must win
      reg_wr(ADDR_STATUS, 8'h01);
      reg_rd(ADDR_STATUS, 8'h01, "set wins over clear");
      // Reference dropout sends the detector back to settling
      ready_dly <= 10'h3FF;
      repeat (4) @(posedge clk);
      reg_rd(ADDR_CTRL, 8'hDF, "reference dropout");
      ready_dly <= 10'h00A;
      repeat (205) @(posedge clk);
      reg_rd(ADDR_CTRL, 8'hFF, "resettled");
      reg_wr(ADDR_CTRL, 8'h00);
      check_val({7'h00, den}, 8'h00, "powered off");
      bgap_ok <= 1'h0;
      repeat (3) @(posedge clk);
      reg_rd(ADDR_CTRL, 8'h00, "band gap low");
      bgap_ok <= 1'h1;
      repeat (3) @(posedge clk);
      reg_rd(ADDR_CTRL, 8'h40, "band gap high");
      $display("test bgap done");
   endtask : t_bgap

   // Cut a hang short well past the expected run length
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         fails++;
         $display("Error at %0t ns: timeout", $time);
         print_verdict();
      end
   end

   initial begin
      repeat (2) @(posedge clk);
      rst <= 1'h0;
      t_reset();
      t_settle();
      t_fall_irq();
      t_levels();
      t_bgap();
      print_verdict();
   end
endmodule : hlv_ctrl_bench
`default_nettype wire
